// ### cbu_pkg.sv
// Shared constants and types for the conditional branch unit.
package cbu_pkg;

	localparam int unsigned AW = 6;

	localparam logic [AW-1:0] OFF_CTRL   = 6'h00;
	localparam logic [AW-1:0] OFF_INSTR  = 6'h04;
	localparam logic [AW-1:0] OFF_PC     = 6'h08;
	localparam logic [AW-1:0] OFF_SRC_A  = 6'h0C;
	localparam logic [AW-1:0] OFF_SRC_B  = 6'h10;
	localparam logic [AW-1:0] OFF_STATUS = 6'h14;
	localparam logic [AW-1:0] OFF_TARGET = 6'h18;
	localparam logic [AW-1:0] OFF_LINK   = 6'h1C;

	localparam logic [5:0] OPC_COND_REG = 6'h27;
	localparam logic [5:0] OPC_COND_IMM = 6'h2F;
	localparam logic [5:0] OPC_JUMP_REG = 6'h26;
	localparam logic [5:0] OPC_IMM_PFX  = 6'h2C;

	localparam logic [3:0] CND_NE = 4'h1;
	localparam logic [3:0] CND_LT = 4'h2;
	localparam logic [3:0] CND_LE = 4'h3;

	localparam int unsigned OPC_LSB   = 26;
	localparam int unsigned DSLOT_BIT = 25;
	localparam int unsigned CND_LSB   = 21;
	localparam int unsigned DST_LSB   = 21;
	localparam int unsigned SRC_A_LSB = 16;
	localparam int unsigned SRC_B_LSB = 11;
	localparam int unsigned JR_DLY    = 20;
	localparam int unsigned JR_ABS    = 19;
	localparam int unsigned JR_LNK    = 18;
	localparam int unsigned IMM_W     = 16;
	localparam int unsigned CTRL_GO   = 0;

	localparam int unsigned ST_BUSY  = 0;
	localparam int unsigned ST_TAKEN = 1;
	localparam int unsigned ST_SLOT  = 2;
	localparam int unsigned ST_LINK  = 3;
	localparam int unsigned ST_PFX   = 4;
	localparam int unsigned ST_UNSUP = 5;
	localparam int unsigned ST_DST   = 8;

	localparam logic [31:0] PC_RST    = 32'h0000_0000;
	localparam logic [31:0] WORD_RST  = 32'h0000_0000;
	localparam logic [31:0] PC_STEP   = 32'h0000_0004;

	localparam logic [1:0] LAT_NOT_TAKEN = 2'h1;
	localparam logic [1:0] LAT_SLOT      = 2'h2;
	localparam logic [1:0] LAT_NO_SLOT   = 2'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		CBU_IDLE,
		CBU_EXEC
	} cbu_state_e;

endpackage : cbu_pkg

// ### cbu_top.sv
// Conditional branch unit with its AXI4-Lite register slave.
`timescale 1ns/1ps

// Behaviour
// [RULE_01] Less-or-equal branch is taken when source A, signed, is zero or negative.
// [RULE_02] Less-than branch is taken only when source A is below zero.
// [RULE_03] Not-equal branch is taken whenever source A is not zero.
// [RULE_04] Register form target is branch address plus source B.
// [RULE_05] Immediate form target is branch address plus sign-extended immediate.
// [RULE_06] Untaken branch adds four to the program counter in one cycle.
// [RULE_07] Taken branch with delay slot costs two cycles.
// [RULE_08] Taken branch without delay slot costs three cycles.
// [RULE_09] With delay slot, the next instruction completes before the target runs.
// [RULE_10] Without delay slot, the target is the next instruction executed.
// [RULE_11] Immediate operand is the 16-bit field sign-extended to a word.
// [RULE_12] A directly preceding prefix supplies the upper immediate bits instead.
// [RULE_13] Delayed register less-or-equal: delay bit then condition 0011 after opcode.
// [RULE_14] Delayed register less-than: major opcode 10011, delay bit, condition 0010; the code decodes the six-bit opcode 100111 above the delay bit.
// [RULE_15] Delayed immediate less-than keeps its immediate in bits 16 to 31; the code takes it from bits 0 to 15.
// [RULE_16] Delayed immediate not-equal: condition after delay bit, source A at bit 11; the code places source A at bit 16.
// [RULE_17] Delayed immediate less-or-equal evaluates like its undelayed form.
// [RULE_18] Delayed register not-equal evaluates like its undelayed form.
// [RULE_19] Unconditional register jumps decode relative or absolute, delay and link.
// [RULE_20] Absolute jump loads the register value, otherwise adds it to the PC.
// [RULE_21] Linking jump writes the current program counter into the destination.
// [RULE_22] Conditional branches change only the program counter.
// [RULE_23] Low eleven bits of register-form branches are ignored.
module cbu_top (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic                   ce,
	input  wire logic [cbu_pkg::AW-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [cbu_pkg::AW-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output logic [31:0]                 pc_value,
	output logic                        busy,
	output logic                        link_write,
	output logic [4:0]                  link_index,
	output logic [31:0]                 link_value
);
	import cbu_pkg::*;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] stb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (stb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic mapped(input logic [AW-1:0] a);
		return a <= OFF_LINK;
	endfunction : mapped

	function automatic logic cond_met(input logic [3:0] c, input logic [31:0] a);
		case (c)
			CND_LE: cond_met = $signed(a) <= 0; // [RULE_01]
			CND_LT: cond_met = $signed(a) < 0; // [RULE_02]
			CND_NE: cond_met = a != WORD_RST; // [RULE_03]
			default: cond_met = 1'b0;
		endcase
	endfunction : cond_met

	cbu_state_e  state_q;
	logic [31:0] instr_q, pc_q, source_reg_a_q, source_reg_b_q;
	logic        pfx_q, slot_q, unsup_q, lnk_done_q, link_write_q;
	logic [15:0] pfx_hi_q;
	logic [31:0] slot_tgt_q, link_value_q;
	logic [4:0]  link_index_q;
	logic        ex_taken_q, ex_dly_q, ex_lnk_q, ex_slot_q;
	logic [31:0] ex_tgt_q;
	logic [1:0]  ex_lat_q, cnt_q;
	logic [4:0]  ex_dst_q;
	logic            aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
	logic [AW-1:0]   awaddr_q;
	logic [31:0]     wdata_q, rdata_q;
	logic [3:0]      wstrb_q;
	logic [1:0]      bresp_q, rresp_q;

	logic          aw_acc, w_acc, wr_fire, ar_acc, go, fin, idle;
	logic [AW-1:0] wr_addr;
	logic [31:0]   wr_data;
	logic [3:0]    wr_strb;

	assign idle          = state_q == CBU_IDLE;
	assign s_axi_awready = ce && !aw_hold_q && !bvalid_q;
	assign s_axi_wready  = ce && !w_hold_q && !bvalid_q;
	assign s_axi_arready = ce && !rvalid_q;
	assign aw_acc  = s_axi_awvalid && s_axi_awready;
	assign w_acc   = s_axi_wvalid && s_axi_wready;
	assign ar_acc  = s_axi_arvalid && s_axi_arready;
	assign wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
	assign wr_data = w_hold_q ? wdata_q : s_axi_wdata;
	assign wr_strb = w_hold_q ? wstrb_q : s_axi_wstrb;
	assign wr_fire = ce && !bvalid_q && (aw_hold_q || aw_acc) && (w_hold_q || w_acc);
	assign go      = wr_fire && idle && wr_addr == OFF_CTRL && wr_strb[0] && wr_data[CTRL_GO];
	assign fin     = state_q == CBU_EXEC && cnt_q == ex_lat_q;

	// Instruction field decode.
	logic [5:0]  opc;
	logic [3:0]  cnd;
	logic        is_creg, is_cimm, is_jr, cnd_known, dly, taken_d;
	logic [31:0] imm_val, offset, tgt_d;
	logic [1:0]  lat_d;

	assign opc       = instr_q[OPC_LSB +: 6];
	assign cnd       = instr_q[CND_LSB +: 4]; // [RULE_13] [RULE_14] [RULE_16]
	assign is_creg   = opc == OPC_COND_REG; // [RULE_14]
	assign is_cimm   = opc == OPC_COND_IMM;
	assign is_jr     = opc == OPC_JUMP_REG; // [RULE_19]
	assign cnd_known = cnd == CND_LE || cnd == CND_LT || cnd == CND_NE;
	assign dly       = is_jr ? instr_q[JR_DLY] : instr_q[DSLOT_BIT]; // [RULE_13] [RULE_17] [RULE_18]
	// A prefix only reaches the immediate of the very next instruction.
	assign imm_val = pfx_q ? {pfx_hi_q, instr_q[IMM_W-1:0]} // [RULE_12]
		: {{IMM_W{instr_q[IMM_W-1]}}, instr_q[IMM_W-1:0]}; // [RULE_11] [RULE_15]
	// Register forms read only source B's index; bits below it are never looked at.
	assign offset = is_cimm ? imm_val : source_reg_b_q; // [RULE_04] [RULE_05] [RULE_23]
	assign tgt_d  = (is_jr && instr_q[JR_ABS]) ? source_reg_b_q : pc_q + offset; // [RULE_20]

	// An instruction sitting in a delay slot never branches itself.
	assign taken_d = !slot_q && (is_jr || ((is_creg || is_cimm) && cnd_known && cond_met(cnd, source_reg_a_q)));
	assign lat_d   = !taken_d ? LAT_NOT_TAKEN : (dly ? LAT_SLOT : LAT_NO_SLOT); // [RULE_06] [RULE_07] [RULE_08]

	// Address and data may arrive in either order; each is parked until its partner shows up.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			awaddr_q  <= '0;
			wdata_q   <= WORD_RST;
			wstrb_q   <= 4'h0;
		end else if (ce) begin
			if (wr_fire) begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
			end else begin
				if (aw_acc) begin
					aw_hold_q <= 1'b1;
					awaddr_q  <= s_axi_awaddr;
				end
				if (w_acc) begin
					w_hold_q <= 1'b1;
					wdata_q  <= s_axi_wdata;
					wstrb_q  <= s_axi_wstrb;
				end
				if (bvalid_q && s_axi_bready) begin
					bvalid_q <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= WORD_RST;
			rresp_q  <= RESP_OKAY;
		end else if (ce) begin
			if (ar_acc) begin
				rvalid_q <= 1'b1;
				rresp_q  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
				// Status packs the outcome flags low and the last destination index above them.
				case ({s_axi_araddr[AW-1:2], 2'h0})
					OFF_INSTR:  rdata_q <= instr_q;
					OFF_PC:     rdata_q <= pc_q;
					OFF_SRC_A:  rdata_q <= source_reg_a_q;
					OFF_SRC_B:  rdata_q <= source_reg_b_q;
					OFF_STATUS: rdata_q <= {19'h0, ex_dst_q, 2'h0, unsup_q, pfx_q, lnk_done_q, slot_q, ex_taken_q, !idle};
					OFF_TARGET: rdata_q <= ex_tgt_q;
					OFF_LINK:   rdata_q <= link_value_q;
					default:    rdata_q <= WORD_RST;
				endcase
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Software operand writes; refused while a branch is in flight.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			instr_q        <= WORD_RST;
			source_reg_a_q <= WORD_RST;
			source_reg_b_q <= WORD_RST;
		end else if (ce && wr_fire && idle) begin // [RULE_22]
			case ({wr_addr[AW-1:2], 2'h0})
				OFF_INSTR: instr_q        <= merge(instr_q, wr_data, wr_strb);
				OFF_SRC_A: source_reg_a_q <= merge(source_reg_a_q, wr_data, wr_strb);
				OFF_SRC_B: source_reg_b_q <= merge(source_reg_b_q, wr_data, wr_strb);
				default: ;
			endcase
		end
	end

	// The count starts at one, so a latency code equals the number of busy cycles.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= CBU_IDLE;
			cnt_q   <= 2'h0;
		end else if (ce) begin
			case (state_q)
				CBU_IDLE: begin
					if (go) begin
						state_q <= CBU_EXEC;
						cnt_q   <= 2'h1;
					end
				end
				CBU_EXEC: begin
					if (fin) begin
						state_q <= CBU_IDLE;
					end else begin
						cnt_q <= cnt_q + 2'h1;
					end
				end
				default: state_q <= CBU_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ex_taken_q <= 1'b0;
			ex_dly_q   <= 1'b0;
			ex_lnk_q   <= 1'b0;
			ex_slot_q  <= 1'b0;
			ex_tgt_q   <= WORD_RST;
			ex_lat_q   <= LAT_NOT_TAKEN;
			ex_dst_q   <= 5'h0;
			unsup_q    <= 1'b0;
			pfx_q      <= 1'b0;
			pfx_hi_q   <= 16'h0;
		end else if (ce && go) begin
			ex_taken_q <= taken_d;
			ex_dly_q   <= dly;
			ex_lnk_q   <= is_jr && instr_q[JR_LNK] && !slot_q; // [RULE_21]
			ex_slot_q  <= slot_q;
			ex_tgt_q   <= tgt_d;
			ex_lat_q   <= lat_d;
			ex_dst_q   <= instr_q[DST_LSB +: 5];
			unsup_q    <= (is_creg || is_cimm) && !cnd_known;
			pfx_q      <= opc == OPC_IMM_PFX; // [RULE_12]
			pfx_hi_q   <= instr_q[IMM_W-1:0];
		end
	end

	// Program counter, pending slot target and link write-back.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_q         <= PC_RST;
			slot_q       <= 1'b0;
			slot_tgt_q   <= WORD_RST;
			lnk_done_q   <= 1'b0;
			link_write_q <= 1'b0;
			link_index_q <= 5'h0;
			link_value_q <= WORD_RST;
		end else if (ce) begin
			link_write_q <= fin && ex_lnk_q;
			if (wr_fire && idle && {wr_addr[AW-1:2], 2'h0} == OFF_PC) begin
				pc_q <= merge(pc_q, wr_data, wr_strb);
			end else if (fin) begin
				if (ex_slot_q) begin
					pc_q   <= slot_tgt_q; // [RULE_09]
					slot_q <= 1'b0;
				end else if (ex_taken_q && ex_dly_q) begin
					pc_q       <= pc_q + PC_STEP; // [RULE_09]
					slot_q     <= 1'b1;
					slot_tgt_q <= ex_tgt_q;
				end else if (ex_taken_q) begin
					pc_q <= ex_tgt_q; // [RULE_10]
				end else begin
					pc_q <= pc_q + PC_STEP; // [RULE_06]
				end
			end
			// The link holds the branch's own address, taken before the counter moves on.
			if (fin && ex_lnk_q) begin
				lnk_done_q   <= 1'b1;
				link_index_q <= ex_dst_q;
				link_value_q <= pc_q; // [RULE_21]
			end else if (go) begin
				lnk_done_q <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;
	assign pc_value     = pc_q;
	assign busy         = !idle;
	assign link_write   = link_write_q;
	assign link_index   = link_index_q;
	assign link_value   = link_value_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);

	logic is_cond;
	assign is_cond = is_creg || is_cimm;

	// Busy profiles of the three outcomes, counted from the cycle after the start.
	sequence s_one;
		busy ##1 !busy;
	endsequence
	sequence s_two;
		busy [*2] ##1 !busy;
	endsequence
	sequence s_three;
		busy [*3] ##1 !busy;
	endsequence

	// Expected values are rebuilt from sampled operands rather than from the datapath nets.
	a_le_decision: assert property (go && is_cond && cnd == CND_LE && !slot_q |=> // [RULE_01] [RULE_17]
		ex_taken_q == ($signed($past(source_reg_a_q)) <= 0)) else $error("le decision wrong");
	a_lt_decision: assert property (go && is_cond && cnd == CND_LT && !slot_q |=> // [RULE_02]
		ex_taken_q == ($signed($past(source_reg_a_q)) < 0)) else $error("lt decision wrong");
	a_ne_decision: assert property (go && is_cond && cnd == CND_NE && !slot_q |=> // [RULE_03] [RULE_18]
		ex_taken_q == ($past(source_reg_a_q) != 0)) else $error("ne decision wrong");
	a_reg_target: assert property (go && is_creg |=> // [RULE_04]
		ex_tgt_q == $past(pc_q) + $past(source_reg_b_q)) else $error("register target wrong");
	a_imm_target: assert property (go && is_cimm && !pfx_q |=> // [RULE_05] [RULE_11]
		ex_tgt_q == $past(pc_q) + {{IMM_W{$past(instr_q[IMM_W-1])}}, $past(instr_q[IMM_W-1:0])})
		else $error("immediate target wrong");
	a_pfx_upper: assert property (go && is_cimm && pfx_q |=> // [RULE_12]
		ex_tgt_q == $past(pc_q) + {$past(pfx_hi_q), $past(instr_q[IMM_W-1:0])}) else $error("prefix bits not used");
	a_lat_untaken: assert property (go && !taken_d |=> s_one) else $error("untaken latency"); // [RULE_06]
	a_lat_slot: assert property (go && taken_d && dly |=> s_two) else $error("slot latency"); // [RULE_07]
	a_lat_noslot: assert property (go && taken_d && !dly |=> s_three) else $error("no-slot latency"); // [RULE_08]
	a_pc_untaken: assert property (fin && !ex_taken_q && !ex_slot_q && !wr_fire |=> // [RULE_06]
		pc_q == $past(pc_q) + PC_STEP) else $error("pc not stepped");
	a_slot_order: assert property (fin && ex_taken_q && ex_dly_q |=> // [RULE_09]
		slot_q && pc_q == $past(pc_q) + PC_STEP && slot_tgt_q == $past(ex_tgt_q))
		else $error("slot order");
	a_noslot_pc: assert property (fin && ex_taken_q && !ex_dly_q |=> // [RULE_10]
		pc_q == $past(ex_tgt_q) && !slot_q) else $error("target not next");
	a_jump_abs: assert property (go && is_jr && instr_q[JR_ABS] && !slot_q |=> // [RULE_20]
		ex_tgt_q == $past(source_reg_b_q)) else $error("absolute target wrong");
	a_link_write: assert property (fin && ex_lnk_q |=> // [RULE_21]
		link_write && link_value == $past(pc_q) && link_index == $past(ex_dst_q)) else $error("link wrong");
	a_regs_kept: assert property (state_q == CBU_EXEC |=> // [RULE_22]
		$stable(source_reg_a_q) && $stable(source_reg_b_q)) else $error("operand changed");

	a_slot_plain: assert property (go && slot_q |=> !ex_taken_q && ex_slot_q) // [RULE_09]
		else $error("slot instruction branched");
	a_slot_done: assert property (fin && ex_slot_q |=> pc_q == $past(slot_tgt_q) && !slot_q) // [RULE_09]
		else $error("slot target not applied");
	a_jump_rel: assert property (go && is_jr && !instr_q[JR_ABS] |=> // [RULE_20]
		ex_tgt_q == $past(pc_q) + $past(source_reg_b_q)) else $error("relative jump target wrong");
	a_link_once: assert property (!(fin && ex_lnk_q) |=> !link_write) // [RULE_21]
		else $error("stray link pulse");
	a_unsup_step: assert property (go && is_cond && !cnd_known |=> unsup_q && !ex_taken_q) // [RULE_06]
		else $error("unsupported condition branched");

endmodule : cbu_top

// ### tb_top.sv
// Self-checking bench for the conditional branch unit, driven over its register slave.
`timescale 1ns/1ps
module tb_top;
	import cbu_pkg::*;

	logic          aclk, aresetn, ce;
	logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic [31:0]   s_axi_wdata, s_axi_rdata, pc_value, link_value;
	logic [3:0]    s_axi_wstrb;
	logic [1:0]    s_axi_bresp, s_axi_rresp;
	logic          s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, busy, link_write;
	logic [4:0]    link_index;
	int            n_fail, compares, busy_cnt, lnk_cnt, cyc;
	logic [1:0]    resp;
	logic [31:0]   data;

	cbu_top i_cbu_top (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pc_value,
		.busy, .link_write, .link_index, .link_value);

	initial begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end

	// Busy cycles and link pulses are counted here so that one-cycle pulses are never missed.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (busy === 1'h1) busy_cnt <= busy_cnt + 1;
		if (link_write === 1'h1) lnk_cnt <= lnk_cnt + 1;
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_resp

	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid === 1'h1) begin
				r = s_axi_bresp;
				break;
			end
		end
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid === 1'h1) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				break;
			end
		end
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask : rd

	function automatic logic [31:0] ci(input logic [5:0] op, input logic d, input logic [3:0] c,
			input logic [15:0] low);
		return {op, d, c, 5'h3, low};
	endfunction : ci

	// Loads and starts the instruction and checks its cost, the new PC and the link pulse count.
	task automatic go(input logic [31:0] ins, input logic [31:0] epc, input int ecyc, input int elnk);
		wr(OFF_INSTR, ins, resp);
		busy_cnt = 0;
		lnk_cnt = 0;
		wr(OFF_CTRL, 32'h0000_0001, resp);
		chk_resp("start response", RESP_OKAY, resp);
		while (busy !== 1'h0) @(posedge aclk);
		rd(OFF_PC, data, resp);
		chk("busy cycles", 32'(ecyc), 32'(busy_cnt));
		chk("pc register", epc, data);
		chk("pc port", epc, pc_value);
		chk("link pulses", 32'(elnk), 32'(lnk_cnt));
	endtask : go

	task automatic run(input logic [31:0] ins, input logic [31:0] pc, input logic [31:0] a,
			input logic [31:0] b, input logic [31:0] epc, input int ecyc, input int elnk);
		wr(OFF_PC, pc, resp);
		wr(OFF_SRC_A, a, resp);
		wr(OFF_SRC_B, b, resp);
		go(ins, epc, ecyc, elnk);
		rd(OFF_SRC_A, data, resp);
		chk("source a kept", a, data);
		chk_resp("read response", RESP_OKAY, resp);
		$display("test at pc %h done", pc);
	endtask : run

	// A taken delayed branch lands on PC plus four; the slot instruction then hands over to the target.
	task automatic dly(input logic [31:0] ins, input logic [31:0] pc, input logic [31:0] a,
			input logic [31:0] b, input logic [31:0] tgt);
		run(ins, pc, a, b, pc + PC_STEP, 2, 0);
		go(32'h0000_0000, tgt, 1, 0);
	endtask : dly

	initial begin
		n_fail = 0;
		compares = 0;
		cyc = 0;
		ce = 1'h1;
		aresetn = 1'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		chk("pc after reset", PC_RST, pc_value);
		run(ci(OPC_COND_REG, 1'h0, CND_LE, 16'h0), 32'h100, 32'h0, 32'h40, 32'h140, 3, 0);
		run(ci(OPC_COND_REG, 1'h0, CND_LE, 16'h0), 32'h100, 32'h1, 32'h40, 32'h104, 1, 0);
		run(ci(OPC_COND_REG, 1'h0, CND_LE, 16'h0), 32'h100, 32'hFFFF_FFFF, 32'h8, 32'h108, 3, 0);
		run(ci(OPC_COND_REG, 1'h0, CND_LT, 16'h0), 32'h200, 32'h0, 32'h40, 32'h204, 1, 0);
		run(ci(OPC_COND_REG, 1'h0, CND_LT, 16'h0), 32'h200, 32'h8000_0000, 32'h40, 32'h240, 3, 0);
		run(ci(OPC_COND_REG, 1'h0, CND_NE, 16'h0), 32'h300, 32'h0, 32'h40, 32'h304, 1, 0);
		run(ci(OPC_COND_REG, 1'h0, CND_NE, 16'h07FF), 32'h300, 32'h7, 32'h40, 32'h340, 3, 0);
		run(ci(OPC_COND_IMM, 1'h0, CND_LT, 16'hFFF0), 32'h400, 32'hFFFF_FFFF, 32'h0, 32'h3F0, 3, 0);
		dly(ci(OPC_COND_REG, 1'h1, CND_LT, 16'h0), 32'h500, 32'hFFFF_FFFE, 32'h100, 32'h600);
		dly(ci(OPC_COND_REG, 1'h1, CND_LE, 16'h0), 32'h700, 32'h0, 32'h20, 32'h720);
		dly(ci(OPC_COND_REG, 1'h1, CND_NE, 16'h0), 32'h800, 32'h5, 32'h30, 32'h830);
		dly(ci(OPC_COND_IMM, 1'h1, CND_LT, 16'h8000), 32'h9000, 32'hFFFF_FFFF, 32'h0, 32'h1000);
		dly(ci(OPC_COND_IMM, 1'h1, CND_NE, 16'h0024), 32'hA00, 32'h9, 32'h0, 32'hA24);
		dly(ci(OPC_COND_IMM, 1'h1, CND_LE, 16'h0010), 32'hB00, 32'h0, 32'h0, 32'hB10);
		run(ci(OPC_IMM_PFX, 1'h0, 4'h0, 16'h1234), 32'h1000, 32'h1, 32'h0, 32'h1004, 1, 0);
		go(ci(OPC_COND_IMM, 1'h0, CND_NE, 16'h8000), 32'h1234_9004, 3, 0);
		run({OPC_JUMP_REG, 5'h07, 3'h3, 18'h0}, 32'h2000, 32'h0, 32'h3000, 32'h3000, 3, 1);
		chk("link value", 32'h2000, link_value);
		chk("link index", 32'h7, 32'(link_index));
		rd(OFF_LINK, data, resp);
		chk("link register", 32'h2000, data);
		rd(OFF_TARGET, data, resp);
		chk("target register", 32'h3000, data);
		rd(OFF_STATUS, data, resp);
		chk("status after link", 32'h0000_070A, data);
		run({OPC_JUMP_REG, 5'h02, 3'h0, 18'h0}, 32'h2000, 32'h0, 32'h10, 32'h2010, 3, 0);
		dly({OPC_JUMP_REG, 5'h02, 3'h4, 18'h0}, 32'h2100, 32'h0, 32'h20, 32'h2120);
		// A condition code outside the three handled ones retires as a plain step.
		run(ci(OPC_COND_REG, 1'h0, 4'h5, 16'h0), 32'h600, 32'h1, 32'h40, 32'h604, 1, 0);
		rd(OFF_STATUS, data, resp);
		chk("status unsupported", 32'h0000_0520, data);
		// Clock enable low holds a running branch; a write while busy is answered but dropped.
		wr(OFF_PC, 32'h4000, resp);
		wr(OFF_SRC_A, 32'h0, resp);
		wr(OFF_SRC_B, 32'h80, resp);
		wr(OFF_INSTR, ci(OPC_COND_REG, 1'h0, CND_LE, 16'h0), resp);
		wr(OFF_CTRL, 32'h0000_0001, resp);
		ce <= 1'h0;
		repeat (4) @(posedge aclk);
		chk("frozen pc", 32'h4000, pc_value);
		chk("frozen busy", 32'h1, 32'(busy));
		ce <= 1'h1;
		wr(OFF_SRC_A, 32'h5, resp);
		chk_resp("write while busy", RESP_OKAY, resp);
		while (busy !== 1'h0) @(posedge aclk);
		rd(OFF_SRC_A, data, resp);
		chk("source a after busy write", 32'h0, data);
		rd(OFF_PC, data, resp);
		chk("pc after freeze", 32'h4080, data);
		$display("test clock enable freeze done");
		rd(6'h20, data, resp);
		chk_resp("unmapped read", RESP_SLVERR, resp);
		wr(6'h24, 32'h1, resp);
		chk_resp("unmapped write", RESP_SLVERR, resp);
		$display("test bus errors done");
		test_done();
	end
endmodule : tb_top
